// *** design/fsr_pkg.sv ***
/*
  Package for the flash status-register write block: opcodes, field
  positions, reset values and the packed layout of status byte two.
  Assumes it is compiled before any design file that names it.
*/
package fsr_pkg;

  // ----------------------------------------------------------------
  // opcodes and framing
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_WR_STATUS_ONE = 8'h01;
  localparam logic [7:0] OPC_WR_STATUS_TWO = 8'h31;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // data byte field positions
  // ----------------------------------------------------------------
  localparam int LOCK_POS = 7;
  localparam int GLOB_HI_POS = 5;
  localparam int GLOB_LO_POS = 2;
  localparam int RESET_EN_POS = 4;
  localparam int LOCKDOWN_EN_POS = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic LOCK_RST = 1'b0;
  localparam logic LATCH_RST = 1'b0;
  localparam logic RESET_EN_RST = 1'b0;
  localparam logic LOCKDOWN_EN_RST = 1'b0;
  localparam logic [2:0] SR2_RSVD_VAL = 3'h0;

  typedef struct packed {
    logic [2:0] rsvd;
    logic reset_cmd_enable;
    logic lockdown_cmd_enable;
    logic program_suspended_flag;
    logic erase_suspended_flag;
    logic ready_busy_flag;
  } fsr_sr2_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_DATA,
    ST_SKIP
  } fsr_state_t;

endpackage

// *** design/fsr_status_write.sv ***
/*
  Status-register control of a serial flash: write-status commands one
  and two, lockdown-enable, reset-enable, suspend and busy flags.
  Assumes the serial pins arrive asynchronously and are oversampled by
  mclk (serial clock well below mclk / 4); neighbouring command logic
  on mclk sends single-cycle request pulses.
*/
// Function
// - lockdown enable is zero at power-up; lockdown and freeze are ignored while zero
// - lockdown enable never self-clears; only write-status two, an accepted freeze or power cycle changes it
// - after a freeze the lockdown enable is forced to zero until the next rstn reset
// - program-suspend and erase-suspend are reported as two separate flags
// - busy flag is one during internal work; host polls until it drops
// - write-status one is opcode 01h plus one data byte; extra bytes ignored
// - byte one: bit 7 lock value, bits 5..2 global protect code
// - on chip-select release after a valid command one, lock updates, latch clears
// - global protect or unprotect follows bits 5..2 and the prior lock value
// - short byte or off-boundary release aborts command one but clears the latch
// - with write-protect asserted lock may only be set; a clear is ignored
// - only write-status two changes reset enable; write-status two or freeze changes lockdown enable; both need latch set
// - write-status two is 31h plus a byte: bit 4 reset, bit 3 lockdown
// - valid command two updates reset enable, lockdown enable unless frozen, clears latch
// - short or off-boundary command two aborts, enables kept, latch cleared
// - reset enable is zero at power-up; reset commands are ignored while zero
// - with the latch clear, protection, lockdown and status writes are refused
`timescale 1ns/10ps
`default_nettype none

module fsr_status_write (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic si_pin,
  input wire logic wp_n_pin,
  input wire logic busy_in,
  input wire logic prog_susp_in,
  input wire logic erase_susp_in,
  input wire logic latch_set,
  input wire logic latch_clr,
  input wire logic lockdown_req,
  input wire logic freeze_req,
  input wire logic reset_req,
  output fsr_pkg::fsr_sr2_t status_byte_two,
  output logic protection_lock_bit,
  output logic write_enable_latch,
  output logic lockdown_frozen,
  output logic lockdown_accept,
  output logic freeze_accept,
  output logic reset_accept,
  output logic glob_op_req,
  output logic [3:0] glob_op_code
);

  // ----------------------------------------------------------------
  // pin synchronisers, two flops before any logic
  // ----------------------------------------------------------------
  logic [3:0] pin_m_q;
  logic [3:0] pin_s_q;
  logic cs_n_d_q;
  logic sclk_d_q;
  wire cs_n_s = pin_s_q[0];
  wire sclk_s = pin_s_q[1];
  wire si_s = pin_s_q[2];
  wire wp_n_s = pin_s_q[3];
  wire cs_fall = cs_n_d_q && !cs_n_s;
  wire cs_rise = !cs_n_d_q && cs_n_s;
  wire sclk_rise = !sclk_d_q && sclk_s && !cs_n_s;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_m_q <= 4'hf;
      pin_s_q <= 4'hf;
      cs_n_d_q <= 1'b1;
      sclk_d_q <= 1'b1;
    end else begin
      pin_m_q <= {wp_n_pin, si_pin, sclk_pin, cs_n_pin};
      pin_s_q <= pin_m_q;
      cs_n_d_q <= cs_n_s;
      sclk_d_q <= sclk_s;
    end
  end

  // ----------------------------------------------------------------
  // command framing
  // ----------------------------------------------------------------
  fsr_pkg::fsr_state_t state_q, state_d;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] opcode_q;
  logic [7:0] data_q;
  logic lockdown_cmd_q;
  logic reset_cmd_q;

  wire [7:0] shift_d = {shift_q[6:0], si_s};
  wire byte_done = sclk_rise && (bit_cnt_q == fsr_pkg::BIT_CNT_LAST);

  always_comb begin
    state_d = state_q;
    if (cs_fall) begin
      state_d = fsr_pkg::ST_OPCODE;
    end else if (cs_rise) begin
      state_d = fsr_pkg::ST_IDLE;
    end else if (byte_done) begin
      unique case (state_q)
        fsr_pkg::ST_OPCODE: state_d = fsr_pkg::ST_DATA;
        fsr_pkg::ST_DATA: state_d = fsr_pkg::ST_SKIP;
        fsr_pkg::ST_SKIP: state_d = fsr_pkg::ST_SKIP;
        fsr_pkg::ST_IDLE: state_d = fsr_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= fsr_pkg::ST_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (cs_fall) begin
        bit_cnt_q <= 3'h0;
      end else if (sclk_rise) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        shift_q <= shift_d;
      end
      if (byte_done && state_q == fsr_pkg::ST_OPCODE) begin
        opcode_q <= shift_d;
      end
      if (byte_done && state_q == fsr_pkg::ST_DATA) begin
        data_q <= shift_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode at chip-select release
  // ----------------------------------------------------------------
  wire opc_known = (state_q == fsr_pkg::ST_DATA) || (state_q == fsr_pkg::ST_SKIP);
  wire is_wr1 = opcode_q == fsr_pkg::OPC_WR_STATUS_ONE;
  wire is_wr2 = opcode_q == fsr_pkg::OPC_WR_STATUS_TWO;
  // a truncated or unknown opcode leaves the latch alone; a full 01h or 31h opcode clears it
  wire wr_end = cs_rise && opc_known && (is_wr1 || is_wr2) && write_enable_latch;
  wire frame_ok = (state_q == fsr_pkg::ST_SKIP) && (bit_cnt_q == 3'h0);
  wire new_lock = data_q[fsr_pkg::LOCK_POS];
  wire wp_block = !wp_n_s && protection_lock_bit && !new_lock;
  wire wr1_ok = wr_end && is_wr1 && frame_ok && !wp_block;
  wire wr2_ok = wr_end && is_wr2 && frame_ok;
  wire glob_go = wr1_ok && !protection_lock_bit;
  wire lockdown_ok = lockdown_req && lockdown_cmd_q && write_enable_latch;
  wire freeze_ok = freeze_req && lockdown_cmd_q && write_enable_latch;

  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      protection_lock_bit <= fsr_pkg::LOCK_RST;
      write_enable_latch <= fsr_pkg::LATCH_RST;
      lockdown_cmd_q <= fsr_pkg::LOCKDOWN_EN_RST;
      reset_cmd_q <= fsr_pkg::RESET_EN_RST;
      lockdown_frozen <= 1'b0;
    end else begin
      if (wr1_ok) begin
        protection_lock_bit <= new_lock;
      end
      // a set request in the same cycle as a clear wins
      if (latch_set) begin
        write_enable_latch <= 1'b1;
      end else if (wr_end || latch_clr) begin
        write_enable_latch <= 1'b0;
      end
      if (freeze_ok) begin
        lockdown_frozen <= 1'b1;
      end
      if (freeze_ok || lockdown_frozen) begin
        lockdown_cmd_q <= 1'b0;
      end else if (wr2_ok) begin
        lockdown_cmd_q <= data_q[fsr_pkg::LOCKDOWN_EN_POS];
      end
      if (wr2_ok) begin
        reset_cmd_q <= data_q[fsr_pkg::RESET_EN_POS];
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  wire fsr_pkg::fsr_sr2_t status_d = '{
    rsvd: fsr_pkg::SR2_RSVD_VAL,
    reset_cmd_enable: reset_cmd_q,
    lockdown_cmd_enable: lockdown_cmd_q,
    program_suspended_flag: prog_susp_in,
    erase_suspended_flag: erase_susp_in,
    ready_busy_flag: busy_in
  };

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status_byte_two <= '0;
      lockdown_accept <= 1'b0;
      freeze_accept <= 1'b0;
      reset_accept <= 1'b0;
      glob_op_req <= 1'b0;
      glob_op_code <= 4'h0;
    end else begin
      status_byte_two <= status_d;
      lockdown_accept <= lockdown_ok;
      freeze_accept <= freeze_ok;
      reset_accept <= reset_req && reset_cmd_q;
      glob_op_req <= glob_go;
      if (glob_go) begin
        glob_op_code <= data_q[fsr_pkg::GLOB_HI_POS:fsr_pkg::GLOB_LO_POS];
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // latch and protection lock
  // ----------------------------------------------------------------
  chk_latch_clears: assert property ((wr_end && !latch_set) |=> !write_enable_latch)
    else $error("latch not cleared after write-status command");
  chk_latch_set: assert property (latch_set |=> write_enable_latch)
    else $error("latch not set by request");
  chk_abort_latch: assert property (
    (wr_end && !frame_ok && !latch_set) |=> !write_enable_latch)
    else $error("latch not cleared after aborted frame");
  chk_lock_source: assert property ($changed(protection_lock_bit) |-> $past(wr1_ok))
    else $error("lock changed without a valid command one");
  chk_lock_value: assert property (wr1_ok |=> protection_lock_bit == $past(new_lock))
    else $error("lock did not take the data value");
  chk_lock_wp: assert property ($fell(protection_lock_bit) |-> $past(wp_n_s))
    else $error("lock cleared while write-protect asserted");
  // a frame released with the latch clear must leave the lock alone
  chk_refused_quiet: assert property (
    (cs_rise && !write_enable_latch) |=> $stable(protection_lock_bit))
    else $error("lock changed by a refused command");

  // ----------------------------------------------------------------
  // reset and lockdown enables
  // ----------------------------------------------------------------
  chk_reset_en_src: assert property ($changed(reset_cmd_q) |-> $past(wr2_ok))
    else $error("reset enable changed without a valid command two");
  chk_lockdown_hold: assert property (
    $changed(lockdown_cmd_q) |-> $past(wr2_ok || freeze_ok || lockdown_frozen))
    else $error("lockdown enable changed on its own");
  chk_frozen_lockdown: assert property (lockdown_frozen |-> !lockdown_cmd_q)
    else $error("lockdown enable set after freeze");
  chk_frozen_sticky: assert property (lockdown_frozen |=> lockdown_frozen)
    else $error("freeze state was lost");
  chk_lockdown_gate: assert property (
    lockdown_accept |-> $past(lockdown_cmd_q && write_enable_latch))
    else $error("lockdown accepted while disabled");
  chk_freeze_gate: assert property (
    freeze_accept |-> $past(lockdown_cmd_q && write_enable_latch))
    else $error("freeze accepted while disabled");
  chk_reset_gate: assert property (reset_accept |-> $past(reset_cmd_q))
    else $error("reset accepted while disabled");
  chk_reset_quiet: assert property ((reset_req && !reset_cmd_q) |=> !reset_accept)
    else $error("reset request not ignored");

  // ----------------------------------------------------------------
  // status flags and global operation
  // ----------------------------------------------------------------
  chk_busy_flag: assert property (busy_in |=> status_byte_two.ready_busy_flag)
    else $error("busy flag did not follow internal operation");
  chk_prog_flag: assert property (
    prog_susp_in |=> status_byte_two.program_suspended_flag)
    else $error("program suspend flag did not follow its input");
  chk_erase_flag: assert property (
    erase_susp_in |=> status_byte_two.erase_suspended_flag)
    else $error("erase suspend flag did not follow its input");
  chk_glob_prior: assert property (
    glob_op_req |-> $past(!protection_lock_bit && wr1_ok))
    else $error("global operation with prior lock set");
  chk_code_value: assert property (
    glob_op_req |-> glob_op_code == $past(data_q[fsr_pkg::GLOB_HI_POS:fsr_pkg::GLOB_LO_POS]))
    else $error("global code does not match data bits");
  chk_abort_quiet: assert property (
    (cs_rise && !frame_ok) |=> !glob_op_req ##1 !glob_op_req)
    else $error("global operation after aborted frame");

  // ----------------------------------------------------------------
  // main scenarios
  // ----------------------------------------------------------------
  cov_wr1_ok: cover property (wr1_ok);
  cov_wr2_ok: cover property (wr2_ok);
  cov_abort: cover property (wr_end && !frame_ok);
  cov_freeze: cover property (freeze_ok);
  cov_wp_block: cover property (wr_end && is_wr1 && wp_block);

endmodule

`default_nettype wire

// *** verif/fsr_host_model.sv ***
/*
  Host serial master model for the status-write block.
  Assumes the bench calls frame() and that mclk is the block's clock.
*/
`timescale 1ns/10ps
`default_nettype none

module fsr_host_model (
  input wire logic mclk,
  output logic cs_n,
  output logic sclk,
  output logic si
);
  // ---------------------------------------------------------------
  // idle levels: clock still, data flips so no stale value is read
  // ---------------------------------------------------------------
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // ---------------------------------------------------------------
  // one frame: nbits taken from the top of bits, msb first
  // ---------------------------------------------------------------
  task automatic frame(input int nbits, input logic [23:0] bits);
    @(posedge mclk) cs_n <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < nbits; i++) begin
      si <= bits[23-i];
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (8) @(posedge mclk);
  endtask
endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
/*
  Self-checking bench for the status-write block.
  Assumes fsr_pkg and the host model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  typedef struct {
    logic wp; int n; logic [23:0] bits; logic lk; logic wl;
    logic [7:0] sr; logic gl; logic [3:0] cd;
  } fsr_tb_row_t;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic wp_n = 1'b1;
  logic [2:0] flg = 3'h0;
  logic [4:0] rq = 5'h00;
  logic [3:0] seen = 4'h0;
  logic seen_clr = 1'b0;
  int error_cnt = 0;
  int check_count = 0;
  wire cs_n, sclk, si, lkb, latch, frz, glob, lacc, facc, racc;
  wire [3:0] code;
  fsr_pkg::fsr_sr2_t sr2;
  fsr_tb_row_t rows [10] = '{
    '{1, 16, 24'h01bc00, 1, 0, 8'h00, 1, 4'hf}, '{0, 16, 24'h010000, 1, 0, 8'h00, 0, 4'h0},
    '{1, 16, 24'h010000, 0, 0, 8'h00, 0, 4'h0}, '{0, 16, 24'h018000, 1, 0, 8'h00, 1, 4'h0},
    '{1, 12, 24'h010000, 1, 0, 8'h00, 0, 4'h0}, '{1, 24, 24'h0114ff, 0, 0, 8'h00, 0, 4'h0},
    '{1, 16, 24'h311800, 0, 0, 8'h18, 0, 4'h0}, '{1, 12, 24'h310000, 0, 0, 8'h18, 0, 4'h0},
    '{1, 16, 24'h3108e7, 0, 0, 8'h08, 0, 4'h0}, '{1, 5, 24'h310000, 0, 1, 8'h08, 0, 4'h0}};

  always #25 mclk = ~mclk;
  always @(posedge mclk) seen <= seen_clr ? 4'h0 : (seen | {glob, lacc, facc, racc});

  fsr_host_model u_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si));
  fsr_status_write u_dut (.mclk(mclk), .rstn(rstn), .cs_n_pin(cs_n), .sclk_pin(sclk),
    .si_pin(si), .wp_n_pin(wp_n), .busy_in(flg[0]), .prog_susp_in(flg[2]),
    .erase_susp_in(flg[1]), .latch_set(rq[4]), .latch_clr(rq[3]), .lockdown_req(rq[2]),
    .freeze_req(rq[1]), .reset_req(rq[0]), .status_byte_two(sr2),
    .protection_lock_bit(lkb), .write_enable_latch(latch), .lockdown_frozen(frz),
    .lockdown_accept(lacc), .freeze_accept(facc), .reset_accept(racc),
    .glob_op_req(glob), .glob_op_code(code));

  // ---------------------------------------------------------------
  // compare, request and closing tasks
  // ---------------------------------------------------------------
  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse(input logic [4:0] v);
    @(posedge mclk) begin
      rq <= v;
      seen_clr <= 1'b1;
    end
    @(posedge mclk) begin
      rq <= 5'h00;
      seen_clr <= 1'b0;
    end
    repeat (3) @(posedge mclk);
  endtask
  task automatic req(input logic [4:0] v, input int i, input logic e);
    pulse(v);
    chk1("accept", e, seen[i]);
  endtask
  task automatic wr(input logic [23:0] b);
    pulse(5'h10);
    u_host.frame(16, b);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    summarize();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    chk8("sr2", 8'h00, sr2);
    foreach (rows[k]) begin
      @(posedge mclk) wp_n <= rows[k].wp;
      pulse(5'h10);
      u_host.frame(rows[k].n, rows[k].bits);
      chk1("lock", rows[k].lk, lkb);
      chk1("latch", rows[k].wl, latch);
      chk8("sr2", rows[k].sr, sr2);
      chk1("glob", rows[k].gl, seen[3]);
      if (rows[k].gl) chk8("code", {4'h0, rows[k].cd}, {4'h0, code});
      $display("row %0d done", k);
    end
    req(5'h04, 2, 1'b1);
    req(5'h01, 0, 1'b0);
    pulse(5'h08);
    chk1("latch", 1'b0, latch);
    req(5'h04, 2, 1'b0);
    u_host.frame(16, 24'h311000);
    chk8("sr2", 8'h08, sr2);
    wr(24'h311800);
    req(5'h01, 0, 1'b1);
    chk8("sr2", 8'h18, sr2);
    pulse(5'h10);
    req(5'h02, 1, 1'b1);
    chk1("frozen", 1'b1, frz);
    chk8("sr2", 8'h10, sr2);
    wr(24'h310800);
    chk8("sr2", 8'h00, sr2);
    pulse(5'h10);
    req(5'h04, 2, 1'b0);
    $display("command tests done");
    for (int j = 0; j < 3; j++) begin
      @(posedge mclk) flg <= 3'h1 << j;
      repeat (3) @(posedge mclk);
      chk8("flags", {5'h00, 3'h1 << j}, sr2);
    end
    @(posedge mclk) flg <= 3'h0;
    for (int t = 0; t < 10 && sr2[0] !== 1'b0; t++) @(posedge mclk);
    chk1("busy", 1'b0, sr2[0]);
    @(posedge mclk) rstn <= 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    chk1("frozen", 1'b0, frz);
    chk1("latch", 1'b0, latch);
    wr(24'h310800);
    chk8("sr2", 8'h08, sr2);
    $display("flag and reset tests done");
    summarize();
  end
endmodule

`default_nettype wire
